//--- can_core_model.sv
// controller core stand-in: turns bench requests into one-cycle strobes
// assumes the bench holds kick for exactly one clock per request
`timescale 1ns/100ps
module can_core_model (
    // clock
    input  wire logic       MCLK,
    // requests: rx, tx, abort, form, bit, timer, wake
    input  wire logic [6:0] kick,
    input  wire logic [2:0] mbx,
    // strobes toward the interrupt block
    output logic      [7:0] mb_rx,
    output logic      [7:0] mb_tx,
    output logic      [7:0] mb_abort,
    output logic            form_err,
    output logic            bit_err,
    output logic            timer_roll,
    output logic            lp_exit
);
    // registered so every strobe is a clean single-cycle pulse
    always_ff @(posedge MCLK) begin
        mb_rx      <= kick[0] ? 8'h01 << mbx : 8'h00;
        mb_tx      <= kick[1] ? 8'h01 << mbx : 8'h00;
        mb_abort   <= kick[2] ? 8'h01 << mbx : 8'h00;
        form_err   <= kick[3];
        bit_err    <= kick[4];
        timer_roll <= kick[5];
        lp_exit    <= kick[6];
    end
endmodule : can_core_model

//--- can_irq_pkg.sv
// package for the CAN interrupt and status block: offsets, bit positions, reset values
// assumes a 32-bit AXI4-Lite register bus and one clock domain
package can_irq_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_MASK_SET    = 8'h00; // interrupt_mask_set_reg, write only
    localparam logic [7:0] OFS_UNMASK      = 8'h04; // interrupt_unmask_reg, write only
    localparam logic [7:0] OFS_MASK_RDBK   = 8'h08; // interrupt_mask_readback_reg
    localparam logic [7:0] OFS_STATUS      = 8'h0C; // controller_status

    // system event bit positions, placed above the mailbox bits
    localparam int BIT_ERR_ACTIVE  = 16;
    localparam int BIT_WARN_LIMIT  = 17;
    localparam int BIT_ERR_PASSIVE = 18;
    localparam int BIT_BUS_OFF     = 19;
    localparam int BIT_SLEEP       = 20;
    localparam int BIT_WAKEUP      = 21;
    localparam int BIT_TIMER_OVF   = 22;
    localparam int BIT_FORM_ERR    = 23;
    localparam int BIT_BIT_ERR     = 24;
    localparam int BIT_RX_BUSY     = 29;
    localparam int BIT_TX_BUSY     = 30;
    localparam int BIT_OVL_BUSY    = 31;

    // reset values
    localparam logic [31:0] RST_MASK   = 32'h0000_0000; // all sources masked
    localparam logic [31:0] RST_STATUS = 32'h0000_0000;

    // warning threshold on error counters
    localparam logic [8:0]  WARN_LIMIT = 9'h060; // 96

    // response codes
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // sleep request tracker states
    typedef enum logic [1:0] {
        SLP_IDLE = 2'b00,
        SLP_WAIT = 2'b01,
        SLP_DONE = 2'b10
    } sleep_st_t;

endpackage : can_irq_pkg

//--- can_irq_properties.sv
// checker for the CAN interrupt block: reset, sleep, status and bus timing
// assumes CE stays high, so nothing is frozen between cause and effect
`timescale 1ns/100ps
module can_irq_properties
    import can_irq_pkg::*;
(
    // clock, reset, core levels, IRQ and SLEEP_ACK
    input wire logic        MCLK, SYS_RST, LOW_POWER_REQ, TX_PENDING,
    input wire logic        RX_ACTIVE, ERR_PASSIVE, BUS_OFF, IRQ, SLEEP_ACK,
    // register bus
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_BVALID,
    input wire logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // status read taken at this edge
    sequence st_rd;
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == OFS_STATUS;
    endsequence
    // address and data taken together
    sequence wr_both;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    a_irq_reset: assert property ($fell(SYS_RST) |-> !IRQ [*2])
        else $error("interrupt raised right after reset");
    a_sleep_cause: assert property ($rose(SLEEP_ACK) |-> $past(LOW_POWER_REQ) && !$past(TX_PENDING))
        else $error("sleep reached without request or with pending tx");
    a_sleep_block: assert property (TX_PENDING |=> !SLEEP_ACK)
        else $error("sleep shown while tx pending");
    a_rx_busy: assert property (st_rd ##0 $stable(RX_ACTIVE) |=> S_AXI_RDATA[BIT_RX_BUSY] == $past(RX_ACTIVE))
        else $error("receiver busy bit wrong");
    a_err_active: assert property (st_rd ##0 $stable(ERR_PASSIVE) && $stable(BUS_OFF)
        |=> S_AXI_RDATA[BIT_ERR_ACTIVE] == !($past(ERR_PASSIVE) || $past(BUS_OFF)))
        else $error("error active bit wrong");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data late");
    a_write_answer: assert property (wr_both |-> ##[1:2] S_AXI_BVALID)
        else $error("write response late");
    a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("address accepted while read data waits");
endmodule : can_irq_properties

bind can_irq_status can_irq_properties i_props (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .LOW_POWER_REQ(LOW_POWER_REQ), .TX_PENDING(TX_PENDING), .RX_ACTIVE(RX_ACTIVE),
    .ERR_PASSIVE(ERR_PASSIVE), .BUS_OFF(BUS_OFF), .IRQ(IRQ), .SLEEP_ACK(SLEEP_ACK),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY));

//--- can_irq_status.sv
// CAN controller interrupt collection, mask registers and status register
// assumes the protocol engine drives one-cycle event strobes and level state inputs,
// all synchronous to MCLK
//
// Notes on behaviour
// R1: sources split into mailbox message events and controller system events
// R2: mask-set write masks, unmask write unmasks, readback shows mask state
// R3: after reset every source is masked
// R4: one status register shows every source state, masked or not
// R5: mailbox event on receive stored or transmit completed
// R6: mailbox event when a requested transmission is aborted
// R7: system event on entering bus-off
// R8: system event on entering error-passive
// R9: error-active shown when neither error-passive nor bus-off
// R10: warning event when error-active and a counter exceeds 96
// R11: wake-up event only after leaving low power and bus resync
// R12: sleep event only after low power requested and transmissions done
// R13: timer overflow event on each timer rollover
// R14: form error flag set on fixed-form violation, cleared by status read
// R15: bit error flag set on bit mismatch, cleared by status read
// R16: receiver busy follows reception of any frame
// R17: transmitter busy follows transmission of any frame
// R18: overload busy follows overload frame transmission
// R19: interrupt output high while any status source active and unmasked
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module can_irq_status
    import can_irq_pkg::*;
#(
    parameter int MAILBOXES = 8
) (
    // clock, reset, enable
    input  wire logic                  MCLK,
    input  wire logic                  SYS_RST,
    input  wire logic                  CE,
    // mailbox event strobes
    input  wire logic [MAILBOXES-1:0]  MB_RX_DONE,
    input  wire logic [MAILBOXES-1:0]  MB_TX_DONE,
    input  wire logic [MAILBOXES-1:0]  MB_TX_ABORT,
    // controller state
    input  wire logic                  ERR_PASSIVE,
    input  wire logic                  BUS_OFF,
    input  wire logic [8:0]            TX_ERR_CNT,
    input  wire logic [7:0]            RX_ERR_CNT,
    input  wire logic                  LOW_POWER_REQ,
    input  wire logic                  TX_PENDING,
    input  wire logic                  LOW_POWER_EXIT,
    input  wire logic                  BUS_SYNCED,
    input  wire logic                  TIMER_ROLL,
    // protocol errors and activity
    input  wire logic                  FORM_ERR,
    input  wire logic                  BIT_ERR,
    input  wire logic                  RX_ACTIVE,
    input  wire logic                  TX_ACTIVE,
    input  wire logic                  OVL_ACTIVE,
    // low power indication toward the core
    output logic                       SLEEP_ACK,
    // interrupt
    output logic                       IRQ,
    // axi4-lite write address
    input  wire logic [7:0]            S_AXI_AWADDR,
    input  wire logic                  S_AXI_AWVALID,
    output logic                       S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0]           S_AXI_WDATA,
    input  wire logic [3:0]            S_AXI_WSTRB,
    input  wire logic                  S_AXI_WVALID,
    output logic                       S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]                 S_AXI_BRESP,
    output logic                       S_AXI_BVALID,
    input  wire logic                  S_AXI_BREADY,
    // axi4-lite read address
    input  wire logic [7:0]            S_AXI_ARADDR,
    input  wire logic                  S_AXI_ARVALID,
    output logic                       S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0]                S_AXI_RDATA,
    output logic [1:0]                 S_AXI_RRESP,
    output logic                       S_AXI_RVALID,
    input  wire logic                  S_AXI_RREADY
);

    // mailbox bits occupy the low half, system bits start at 16
    initial begin
        if (MAILBOXES < 1 || MAILBOXES > 16) begin
            $error("MAILBOXES must be 1 to 16");
        end
    end

    typedef struct packed {
        logic [31:0] mask;       // 1 = unmasked
        logic [31:0] sticky;     // event bits
        logic        pass_q;     // previous error-passive
        logic        boff_q;     // previous bus-off
        logic        warn_q;     // previous warning level
        logic        wake_arm;   // left low power, waiting for resync
        sleep_st_t   slp;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_t;

    state_t s_q;
    state_t s_d;

    // byte-lane merge for a write
    function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : lanes

    // level-type bits built live from the core
    logic [31:0] live;
    logic        err_active;
    logic        warn_lvl;
    logic [31:0] status_now;
    logic [31:0] ev_set;
    logic [31:0] mb_bits;

    always_comb begin
        err_active = !ERR_PASSIVE && !BUS_OFF;                                   // R9
        warn_lvl   = err_active && (TX_ERR_CNT > WARN_LIMIT ||
                                    {1'b0, RX_ERR_CNT} > WARN_LIMIT);            // R10
        live                  = 32'h0000_0000;
        live[BIT_ERR_ACTIVE]  = err_active;                                      // R9
        live[BIT_ERR_PASSIVE] = ERR_PASSIVE;
        live[BIT_BUS_OFF]     = BUS_OFF;
        live[BIT_RX_BUSY]     = RX_ACTIVE;                                       // R16
        live[BIT_TX_BUSY]     = TX_ACTIVE;                                       // R17
        live[BIT_OVL_BUSY]    = OVL_ACTIVE;                                      // R18
        mb_bits = 32'h0000_0000;
        mb_bits[MAILBOXES-1:0] = MB_RX_DONE | MB_TX_DONE | MB_TX_ABORT;          // R1 R5 R6
        status_now = live | s_q.sticky;                                          // R4
    end

    // event capture
    always_comb begin
        ev_set                  = mb_bits;                                       // R1
        ev_set[BIT_BUS_OFF]     = BUS_OFF && !s_q.boff_q;                        // R7
        ev_set[BIT_ERR_PASSIVE] = ERR_PASSIVE && !s_q.pass_q;                    // R8
        ev_set[BIT_WARN_LIMIT]  = warn_lvl && !s_q.warn_q;                       // R10
        ev_set[BIT_WAKEUP]      = s_q.wake_arm && BUS_SYNCED;                    // R11
        ev_set[BIT_SLEEP]       = s_q.slp == SLP_WAIT && !TX_PENDING;            // R12
        ev_set[BIT_TIMER_OVF]   = TIMER_ROLL;                                    // R13
        ev_set[BIT_FORM_ERR]    = FORM_ERR;                                      // R14
        ev_set[BIT_BIT_ERR]     = BIT_ERR;                                       // R15
    end

    // next state: bus slave, masks, sticky events
    always_comb begin
        logic        wr_fire;
        logic        rd_fire;
        logic [31:0] wv;
        logic [31:0] clr;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        wv      = 32'h0000_0000;
        clr     = 32'h0000_0000;
        s_d     = s_q;

        s_d.pass_q = ERR_PASSIVE;
        s_d.boff_q = BUS_OFF;
        s_d.warn_q = warn_lvl;

        // wake-up arms on leaving low power, fires once resynced
        if (LOW_POWER_EXIT) begin
            s_d.wake_arm = 1'b1;
        end else if (s_q.wake_arm && BUS_SYNCED) begin
            s_d.wake_arm = 1'b0;                                                 // R11
        end

        // sleep tracker waits for the transmit queue to drain
        case (s_q.slp)
            SLP_IDLE: begin
                if (LOW_POWER_REQ) begin
                    s_d.slp = SLP_WAIT;
                end
            end
            SLP_WAIT: begin
                if (!LOW_POWER_REQ) begin
                    s_d.slp = SLP_IDLE;
                end else if (!TX_PENDING) begin
                    s_d.slp = SLP_DONE;                                          // R12
                end
            end
            SLP_DONE: begin
                if (!LOW_POWER_REQ) begin
                    s_d.slp = SLP_IDLE;
                end
            end
            default: s_d.slp = SLP_IDLE;
        endcase

        // write channels taken in either order, held until the write is done and the response is raised
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = S_AXI_WDATA;
            s_d.w_strb = S_AXI_WSTRB;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            wr_fire    = 1'b1;
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            wv = lanes(s_q.w_data, s_q.w_strb);
            case ({s_q.aw_addr[7:2], 2'b00})
                OFS_MASK_SET: s_d.mask = s_q.mask & ~wv;                         // R2
                OFS_UNMASK:   s_d.mask = s_q.mask | wv;                          // R2
                OFS_MASK_RDBK, OFS_STATUS: ;                                     // read only
                default:      s_d.bresp = RESP_SLVERR;
            endcase
        end
        if (s_q.bvalid && S_AXI_BREADY) begin
            s_d.bvalid = 1'b0;
        end

        // read: one cycle from address to data
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rd_fire    = 1'b1;
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            case ({S_AXI_ARADDR[7:2], 2'b00})
                OFS_MASK_RDBK: s_d.rdata = s_q.mask;                             // R2
                OFS_STATUS: begin
                    s_d.rdata = status_now;                                      // R4
                    clr = s_q.sticky;                            // read clears the sticky bits it shows, not the live level bits
                end
                OFS_MASK_SET, OFS_UNMASK: s_d.rdata = 32'h0000_0000;
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_q.rvalid && S_AXI_RREADY) begin
            s_d.rvalid = 1'b0;
        end

        // a new event in the clearing cycle survives the read
        s_d.sticky = ((s_q.sticky & ~clr) | ev_set) & ~live;                     // R14 R15
        s_d.mask   = s_d.mask;

        if (SYS_RST) begin
            s_d        = '0;
            s_d.mask   = RST_MASK;                                               // R3
            s_d.sticky = RST_STATUS;
            s_d.slp    = SLP_IDLE;
        end
    end

    // single register stage; CE freezes all state except reset, but IRQ still follows the live level inputs
    always_ff @(posedge MCLK) begin
        if (CE || SYS_RST) begin
            s_q <= s_d;
        end
    end

    // handshake and outputs
    assign S_AXI_AWREADY = !s_q.aw_got && !SYS_RST && CE;
    assign S_AXI_WREADY  = !s_q.w_got && !SYS_RST && CE;
    assign S_AXI_ARREADY = !s_q.rvalid && !SYS_RST && CE;
    assign S_AXI_BVALID  = s_q.bvalid;
    assign S_AXI_BRESP   = s_q.bresp;
    assign S_AXI_RVALID  = s_q.rvalid;
    assign S_AXI_RDATA   = s_q.rdata;
    assign S_AXI_RRESP   = s_q.rresp;
    assign SLEEP_ACK     = s_q.slp == SLP_DONE;
    assign IRQ           = |(status_now & s_q.mask);                             // R19

endmodule : can_irq_status

//--- test_can_irq_status.sv
// self-checking bench for the CAN interrupt block over AXI4-Lite
// assumes can_core_model supplies the event strobes; CE tied high
`timescale 1ns/100ps
module test_can_irq_status;
    import can_irq_pkg::*;
    logic        MCLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        err_passive, bus_off, lp_req, tx_pend, synced, rx_act, tx_act, ovl_act;
    logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic        arready, rvalid, form_err, bit_err, timer_roll, lp_exit, sleep_ack, irq;
    logic [8:0]  tx_cnt;
    logic [7:0]  rx_cnt, awaddr, araddr, mb_rx, mb_tx, mb_abort;
    logic [31:0] wdata, d, rdata;
    logic [6:0]  kick;
    logic [2:0]  mbx;
    logic [1:0]  r, bresp, rresp;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    always #4 MCLK = ~MCLK;

    can_core_model i_core (.MCLK(MCLK), .kick(kick), .mbx(mbx), .mb_rx(mb_rx), .mb_tx(mb_tx),
        .mb_abort(mb_abort), .form_err(form_err), .bit_err(bit_err),
        .timer_roll(timer_roll), .lp_exit(lp_exit));

    can_irq_status i_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CE(1'b1), .MB_RX_DONE(mb_rx),
        .MB_TX_DONE(mb_tx), .MB_TX_ABORT(mb_abort), .ERR_PASSIVE(err_passive),
        .BUS_OFF(bus_off), .TX_ERR_CNT(tx_cnt), .RX_ERR_CNT(rx_cnt), .LOW_POWER_REQ(lp_req),
        .TX_PENDING(tx_pend), .LOW_POWER_EXIT(lp_exit), .BUS_SYNCED(synced),
        .TIMER_ROLL(timer_roll), .FORM_ERR(form_err), .BIT_ERR(bit_err), .RX_ACTIVE(rx_act),
        .TX_ACTIVE(tx_act), .OVL_ACTIVE(ovl_act), .SLEEP_ACK(sleep_ack), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    // masked compare; an unknown in a checked bit never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        samples_checked++;
        if (((got ^ exp) & msk) !== 32'h0) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h mask %h", $time, got, exp, msk);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask : tick

    // each channel released at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge MCLK);
        awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge MCLK);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge MCLK);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge MCLK);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic sts(input logic [31:0] exp, input logic [31:0] msk);
        rd(OFS_STATUS);
        chk(d, exp, msk);
    endtask : sts

    task automatic ev(input int k, input logic [2:0] m);
        @(posedge MCLK);
        kick <= 7'h01 << k; mbx <= m;
        @(posedge MCLK);
        kick <= 7'h00;
    endtask : ev

    task automatic give_verdict();
        if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // hang guard, far above the roughly 150 cycles the sequence needs
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        {err_passive, bus_off, lp_req, tx_pend, synced, rx_act, tx_act, ovl_act} = 8'h00;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {tx_cnt, rx_cnt, kick, mbx} = '0;
        tick(16);
        SYS_RST <= 1'b0;
        rd(OFS_MASK_RDBK); chk(d, 32'h0, 32'hFFFF_FFFF);
        chk({31'h0, irq}, 32'h0, 32'h1);
        wr(OFS_UNMASK, 32'h0100_0089); rd(OFS_MASK_RDBK); chk(d, 32'h0100_0089, 32'hFFFF_FFFF);
        wr(OFS_MASK_SET, 32'h0000_0009); rd(OFS_MASK_RDBK); chk(d, 32'h0100_0080, 32'hFFFF_FFFF);
        ev(0, 3'd0); ev(1, 3'd3); ev(2, 3'd7); tick(2);
        chk({31'h0, irq}, 32'h1, 32'h1);
        sts(32'h0000_0089, 32'h0000_00FF);
        sts(32'h0, 32'h0000_00FF); chk({31'h0, irq}, 32'h0, 32'h1);
        ev(3, 3'd0); ev(4, 3'd0); sts(32'h0180_0000, 32'h0180_0000);
        sts(32'h0, 32'h0180_0000);
        synced <= 1'b1; ev(5, 3'd0); ev(6, 3'd0); tick(2);
        sts(32'h0060_0000, 32'h0060_0000);
        bus_off <= 1'b1; tick(3); sts(32'h0008_0000, 32'h0009_0000);
        bus_off <= 1'b0; err_passive <= 1'b1; tick(3); sts(32'h0004_0000, 32'h0005_0000);
        err_passive <= 1'b0; tick(3); sts(32'h0001_0000, 32'h0001_0000);
        sts(32'h0, 32'h0002_0000); tx_cnt <= 9'h060; tick(3); sts(32'h0, 32'h0002_0000);
        tx_cnt <= 9'h061; tick(3); sts(32'h0002_0000, 32'h0002_0000);
        tx_cnt <= 9'h000; tick(3); sts(32'h0, 32'h0002_0000);
        rx_cnt <= 8'h61; tick(3); sts(32'h0002_0000, 32'h0002_0000);
        lp_req <= 1'b1; tx_pend <= 1'b1; tick(3); sts(32'h0, 32'h0010_0000);
        chk({31'h0, sleep_ack}, 32'h0, 32'h1);
        tx_pend <= 1'b0; tick(3); chk({31'h0, sleep_ack}, 32'h1, 32'h1);
        sts(32'h0010_0000, 32'h0010_0000);
        {rx_act, tx_act, ovl_act} <= 3'h7; tick(3); sts(32'hE000_0000, 32'hE000_0000);
        {rx_act, tx_act, ovl_act} <= 3'h0; tick(3); sts(32'h0, 32'hE000_0000);
        rd(8'h10); chk({30'h0, r}, {30'h0, RESP_SLVERR}, 32'h3);
        wr(8'h10, 32'h0); chk({30'h0, r}, {30'h0, RESP_SLVERR}, 32'h3);
        wr(OFS_STATUS, 32'hFFFF_FFFF); chk({30'h0, r}, {30'h0, RESP_OKAY}, 32'h3);
        give_verdict();
    end
endmodule : test_can_irq_status
